// ### pcu_pkg.sv
package pcu_pkg;

    // parameter addresses of the capture block on the fieldbus parameter port
    localparam logic [15:0] PCU_ADDR_STATUS = 16'h0a02;
    localparam logic [15:0] PCU_ADDR_EDGE = 16'h0a06;
    localparam logic [15:0] PCU_ADDR_ARM = 16'h0a0a;
    localparam logic [15:0] PCU_ADDR_POS = 16'h0a0e;
    localparam logic [15:0] PCU_ADDR_COUNT = 16'h0a12;

    // values written to the arm control, and the largest edge select value
    localparam logic [31:0] PCU_ARM_ABORT = 32'h0000_0000;
    localparam logic [31:0] PCU_ARM_SINGLE = 32'h0000_0001;
    localparam logic [31:0] PCU_ARM_CONT = 32'h0000_0002;
    localparam logic [31:0] PCU_EDGE_MAX = 32'h0000_0001;

    // status word bit positions
    localparam int PCU_STAT_A_BIT = 0;
    localparam int PCU_STAT_B_BIT = 1;

    // reset values
    localparam logic PCU_EDGE_RESET = 1'b0;
    localparam logic [15:0] PCU_COUNT_RESET = 16'h0000;
    localparam logic [31:0] PCU_POS_RESET = 32'h0000_0000;
    localparam logic [2:0] PCU_SYNC_RESET = 3'h0;

    // fractional bits of the position scale factor
    localparam int PCU_SCALE_FRAC = 8;

    typedef enum logic [1:0] {
        PCU_IDLE = 2'b00,
        PCU_SINGLE = 2'b01,
        PCU_CONT = 2'b10
    } pcu_mode_t;

    typedef struct packed {
        logic [2:0] cap_sync;
        pcu_mode_t mode;
        logic armed;
        logic edge_rising;
        logic [15:0] count;
        logic [31:0] raw;
        logic [31:0] latched;
        logic stat_a;
        logic stat_b;
        logic ack;
        logic err;
        logic [31:0] rdata;
        logic event_pulse;
    } pcu_state_t;

endpackage

// ### pcu_scaler.sv
`timescale 1ns/1ps
module pcu_scaler
    import pcu_pkg::*;
#(
    parameter int FRAC = PCU_SCALE_FRAC
)
(
    input wire logic signed [31:0] raw,
    input wire logic signed [15:0] scale,
    input wire logic signed [31:0] origin,
    output logic signed [31:0] user
);

    logic signed [47:0] product;
    logic signed [47:0] shifted;

    // user units are a fixed-point multiple of internal counts, offset by the origin
    assign product = raw * scale;
    assign shifted = product >>> FRAC;
    assign user = shifted[31:0] + origin;

endmodule // pcu_scaler

// ### pcu_capture_b.sv
`timescale 1ns/1ps
module pcu_capture_b
    import pcu_pkg::*;
#(
    parameter int SCALE_FRAC = PCU_SCALE_FRAC
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic capture_input_b,
    input wire logic signed [31:0] position_raw,
    input wire logic signed [15:0] position_scale,
    input wire logic signed [31:0] position_origin,
    input wire logic scaling_changed,
    input wire logic homing_done,
    input wire logic control_source_fieldbus,
    input wire logic capture_a_done,
    input wire logic capture_a_arm,
    input wire logic param_req,
    input wire logic param_we,
    input wire logic [15:0] param_addr,
    input wire logic [31:0] param_wdata,
    output logic param_ack,
    output logic param_err,
    output logic [31:0] param_rdata,
    output logic capture_b_armed,
    output logic capture_b_event
);

    pcu_state_t s;
    pcu_state_t next_s;

    logic rise;
    logic fall;
    logic hit;
    logic arm_wr;
    logic arm_accept;
    logic arm_refused_src;
    logic ro_write;
    logic signed [31:0] scaler_raw;
    logic signed [31:0] scaler_user;

    // only the second and third sync stages feed the edge detector
    assign rise = s.cap_sync[1] & ~s.cap_sync[2];
    assign fall = ~s.cap_sync[1] & s.cap_sync[2];
    assign hit = (s.mode != PCU_IDLE) && (s.edge_rising ? rise : fall);
    assign arm_wr = param_req && param_we && (param_addr == PCU_ADDR_ARM);
    assign arm_accept = arm_wr && ((param_wdata == PCU_ARM_SINGLE)
        || (param_wdata == PCU_ARM_CONT)) && control_source_fieldbus;
    assign arm_refused_src = arm_wr && ((param_wdata == PCU_ARM_SINGLE)
        || (param_wdata == PCU_ARM_CONT)) && !control_source_fieldbus;
    assign ro_write = param_req && param_we && ((param_addr == PCU_ADDR_STATUS)
        || (param_addr == PCU_ADDR_POS) || (param_addr == PCU_ADDR_COUNT));

    // one scaler serves both a fresh capture and a recompute of the stored count
    assign scaler_raw = hit ? position_raw : s.raw;

    pcu_scaler #(
        .FRAC(SCALE_FRAC)
    ) u_scaler (
        .raw(scaler_raw),
        .scale(position_scale),
        .origin(position_origin),
        .user(scaler_user)
    );

    always_comb
    begin
        next_s = s;
        next_s.cap_sync = {s.cap_sync[1:0], capture_input_b};
        next_s.ack = 1'b0;
        next_s.err = 1'b0;
        next_s.event_pulse = 1'b0;

        // the position is taken two cycles after the pin edge, the sync delay
        if (hit)
        begin
            next_s.raw = position_raw;
            next_s.latched = scaler_user;
            next_s.count = s.count + 16'h0001;
            next_s.event_pulse = 1'b1;
            if (s.mode == PCU_SINGLE)
            begin
                next_s.mode = PCU_IDLE;
            end
        end
        else if (scaling_changed || homing_done)
        begin
            // the raw count is kept so the user value can follow a new scale or origin
            next_s.latched = scaler_user;
        end

        if (param_req)
        begin
            next_s.ack = 1'b1;
            next_s.rdata = 32'h0000_0000;
            if (param_addr == PCU_ADDR_STATUS)
            begin
                if (param_we)
                begin
                    next_s.err = 1'b1;
                end
                else
                begin
                    next_s.rdata[PCU_STAT_A_BIT] = s.stat_a;
                    next_s.rdata[PCU_STAT_B_BIT] = s.stat_b;
                end
            end
            else if (param_addr == PCU_ADDR_EDGE)
            begin
                if (!param_we)
                begin
                    next_s.rdata[0] = s.edge_rising;
                end
                else if (param_wdata <= PCU_EDGE_MAX)
                begin
                    next_s.edge_rising = param_wdata[0];
                end
                else
                begin
                    next_s.err = 1'b1;
                end
            end
            else if (param_addr == PCU_ADDR_ARM)
            begin
                if (!param_we)
                begin
                    next_s.rdata[1:0] = s.mode;
                end
                else if (param_wdata == PCU_ARM_ABORT)
                begin
                    next_s.mode = PCU_IDLE;
                    next_s.stat_b = hit;
                end
                else if (arm_accept)
                begin
                    next_s.mode = (param_wdata == PCU_ARM_SINGLE) ? PCU_SINGLE : PCU_CONT;
                    next_s.count = PCU_COUNT_RESET;
                    next_s.stat_b = hit;
                end
                else
                begin
                    // out-of-range value, or arming while not under fieldbus control
                    next_s.err = 1'b1;
                end
            end
            else if (param_addr == PCU_ADDR_POS)
            begin
                if (param_we)
                begin
                    next_s.err = 1'b1;
                end
                else
                begin
                    next_s.rdata = s.latched;
                end
            end
            else if (param_addr == PCU_ADDR_COUNT)
            begin
                if (param_we)
                begin
                    next_s.err = 1'b1;
                end
                else
                begin
                    next_s.rdata[15:0] = s.count;
                end
            end
            else
            begin
                next_s.err = 1'b1;
            end
        end

        // a capture in the same cycle as a clear still leaves its bit set
        if (hit)
        begin
            next_s.stat_b = 1'b1;
        end
        if (capture_a_arm)
        begin
            next_s.stat_a = 1'b0;
        end
        if (capture_a_done)
        begin
            next_s.stat_a = 1'b1;
        end
        // armed is kept as its own flop so the output has no decode behind it
        next_s.armed = (next_s.mode != PCU_IDLE);
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s.cap_sync <= PCU_SYNC_RESET;
            s.mode <= PCU_IDLE;
            s.armed <= 1'b0;
            s.edge_rising <= PCU_EDGE_RESET;
            s.count <= PCU_COUNT_RESET;
            s.raw <= PCU_POS_RESET;
            s.latched <= PCU_POS_RESET;
            s.stat_a <= 1'b0;
            s.stat_b <= 1'b0;
            s.ack <= 1'b0;
            s.err <= 1'b0;
            s.rdata <= 32'h0000_0000;
            s.event_pulse <= 1'b0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign param_ack = s.ack;
    assign param_err = s.err;
    assign param_rdata = s.rdata;
    assign capture_b_armed = s.armed;
    assign capture_b_event = s.event_pulse;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_arm_ok;
        arm_accept && !hit;
    endsequence

    sequence s_capture_taken;
        hit && !arm_wr;
    endsequence

    property p_arm_bad_value;
        (arm_wr && (param_wdata > PCU_ARM_CONT)) |=> param_err && param_ack;
    endproperty
    a_arm_bad_value: assert property (p_arm_bad_value) else $error("bad arm value accepted");

    property p_single_stop;
        (s.mode == PCU_SINGLE) and s_capture_taken |=> (s.mode == PCU_IDLE) ##1 !capture_b_event;
    endproperty
    a_single_stop: assert property (p_single_stop) else $error("single capture did not disarm");

    property p_cont_stays;
        (s.mode == PCU_CONT) and s_capture_taken |=> (s.mode == PCU_CONT) && capture_b_event;
    endproperty
    a_cont_stays: assert property (p_cont_stays) else $error("continuous capture stopped");

    property p_no_arm_local;
        arm_refused_src && (s.mode == PCU_IDLE) |=> param_err && !capture_b_armed;
    endproperty
    a_no_arm_local: assert property (p_no_arm_local) else $error("armed without fieldbus control");

    property p_edge_polarity;
        (s.mode != PCU_IDLE) && (rise || fall)
            |=> capture_b_event == ($past(s.edge_rising) ? $past(rise) : $past(fall));
    endproperty
    a_edge_polarity: assert property (p_edge_polarity) else $error("capture on wrong edge");

    property p_count_step;
        s_capture_taken |=> s.count == $past(s.count) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("event counter did not step");

    property p_count_clear;
        s_arm_ok ##1 !hit |=> s.count == PCU_COUNT_RESET;
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("counter not cleared on arming");

    property p_pos_latch;
        hit |=> (s.raw == $past(position_raw)) && (s.latched == $past(scaler_user));
    endproperty
    a_pos_latch: assert property (p_pos_latch) else $error("captured position wrong");

    property p_recompute;
        (scaling_changed || homing_done) && !hit |=> s.latched == $past(scaler_user);
    endproperty
    a_recompute: assert property (p_recompute) else $error("position not recomputed");

    property p_stat_a;
        capture_a_done |=> s.stat_a;
    endproperty
    a_stat_a: assert property (p_stat_a) else $error("channel one status not set");

    property p_stat_b;
        hit |=> s.stat_b;
    endproperty
    a_stat_b: assert property (p_stat_b) else $error("channel two status not set");

    property p_arm_clears_stat;
        s_arm_ok |=> !s.stat_b;
    endproperty
    a_arm_clears_stat: assert property (p_arm_clears_stat) else $error("status not cleared");

    property p_ro_write;
        ro_write && !hit && !scaling_changed && !homing_done
            |=> param_err && (s.count == $past(s.count))
            && (s.latched == $past(s.latched));
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only word changed");

endmodule // pcu_capture_b

// ### pcu_master.sv
`timescale 1ns/1ps
module pcu_master
(
    input wire logic clock,
    input wire logic param_ack,
    input wire logic param_err,
    input wire logic [31:0] param_rdata,
    output logic param_req = 1'b0,
    output logic param_we = 1'b0,
    output logic [15:0] param_addr = 16'h0000,
    output logic [31:0] param_wdata = 32'h0000_0000
);
    // request is a single-cycle pulse; qualifiers turn to their inverse once taken
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
        output logic e, output logic [31:0] q, output int c);
        int n = 0;
        @(posedge clock);
        param_req <= 1'b1;
        param_we <= w;
        param_addr <= a;
        param_wdata <= d;
        @(posedge clock);
        param_req <= 1'b0;
        param_we <= ~w;
        param_addr <= ~a;
        param_wdata <= ~d;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (param_ack !== 1'b1 && n < 8);
        e = param_err;
        q = param_rdata;
        c = n;
    endtask
endmodule // pcu_master

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import pcu_pkg::*;
    logic clock, rst = 1'b1, pin = 1'b0, sc = 1'b0, hom = 1'b0, fb = 1'b0;
    logic a_done = 1'b0, a_arm = 1'b0, req, we, ack, err, armed, ev;
    logic signed [31:0] raw = 32'sh0, org = 32'sh0, pv;
    logic signed [15:0] scl = 16'sh0100;
    logic [15:0] addr, lf = 16'hdc9e;
    logic [31:0] wd, rd;
    logic [15:0] regs [5] = '{PCU_ADDR_STATUS, PCU_ADDR_EDGE, PCU_ADDR_ARM,
        PCU_ADDR_POS, PCU_ADDR_COUNT};
    int num_errors = 0, compares = 0, cyc = 0, nev = 0;
    pcu_capture_b uut (.clock(clock), .rst(rst), .capture_input_b(pin), .position_raw(raw),
        .position_scale(scl), .position_origin(org), .scaling_changed(sc),
        .homing_done(hom), .control_source_fieldbus(fb), .capture_a_done(a_done),
        .capture_a_arm(a_arm), .param_req(req), .param_we(we), .param_addr(addr),
        .param_wdata(wd), .param_ack(ack), .param_err(err), .param_rdata(rd),
        .capture_b_armed(armed), .capture_b_event(ev));
    pcu_master m (.clock(clock), .param_ack(ack), .param_err(err), .param_rdata(rd),
        .param_req(req), .param_we(we), .param_addr(addr), .param_wdata(wd));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] user(input logic signed [31:0] r,
        input logic signed [15:0] s, input logic signed [31:0] o);
        logic signed [63:0] p;
        p = r * s;
        return 32'(p >>> 8) + o;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
        input logic ee, input logic [31:0] e);
        logic er;
        logic [31:0] q;
        int c;
        m.xfer(w, a, d, er, q, c);
        chk("ack_cycles", 1, c);
        chk("param_err", {31'h0, ee}, {31'h0, er});
        if (!w && !ee)
            chk("param_rdata", e, q);
    endtask
    // pin held 5 clocks per level, well above the synchroniser minimum
    task automatic toggle();
        @(posedge clock);
        pin <= ~pin;
        repeat (4) @(posedge clock);
    endtask
    task automatic close_out();
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cyc++;
        if (ev === 1'b1)
            nev++;
        if (cyc == 20000)
        begin
            num_errors++;
            close_out();
        end
    end
    initial
    begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        foreach (regs[i])
            acc(1'b0, regs[i], 0, 1'b0, 0);
        acc(1'b0, 16'h0a04, 0, 1'b1, 0);
        acc(1'b1, PCU_ADDR_ARM, PCU_ARM_SINGLE, 1'b1, 0);
        chk("armed", 0, {31'h0, armed});
        fb <= 1'b1;
        acc(1'b1, PCU_ADDR_EDGE, 2, 1'b1, 0);
        acc(1'b1, PCU_ADDR_EDGE, 1, 1'b0, 0);
        acc(1'b1, PCU_ADDR_ARM, 3, 1'b1, 0);
        acc(1'b1, PCU_ADDR_ARM, PCU_ARM_CONT, 1'b0, 0);
        chk("armed", 1, {31'h0, armed});
        acc(1'b0, PCU_ADDR_ARM, 0, 1'b0, PCU_ARM_CONT);
        for (int i = 1; i <= 3; i++)
        begin
            lf = lfsr(lf);
            pv = {{16{lf[15]}}, lf};
            raw <= pv;
            toggle();
            toggle();
            acc(1'b0, PCU_ADDR_POS, 0, 1'b0, user(pv, scl, org));
            acc(1'b0, PCU_ADDR_COUNT, 0, 1'b0, i);
        end
        chk("events", 3, nev);
        acc(1'b0, PCU_ADDR_STATUS, 0, 1'b0, 2);
        lf = lfsr(lf);
        scl <= lf;
        sc <= 1'b1;
        @(posedge clock);
        sc <= 1'b0;
        acc(1'b0, PCU_ADDR_POS, 0, 1'b0, user(pv, lf, org));
        lf = lfsr(lf);
        org <= {lf, 16'h0};
        hom <= 1'b1;
        @(posedge clock);
        hom <= 1'b0;
        acc(1'b0, PCU_ADDR_POS, 0, 1'b0, user(pv, scl, {lf, 16'h0}));
        acc(1'b1, PCU_ADDR_ARM, PCU_ARM_ABORT, 1'b0, 0);
        acc(1'b0, PCU_ADDR_STATUS, 0, 1'b0, 0);
        toggle();
        toggle();
        chk("events", 3, nev);
        acc(1'b1, PCU_ADDR_EDGE, 0, 1'b0, 0);
        acc(1'b1, PCU_ADDR_ARM, PCU_ARM_SINGLE, 1'b0, 0);
        acc(1'b0, PCU_ADDR_COUNT, 0, 1'b0, 0);
        repeat (4)
            toggle();
        chk("events", 4, nev);
        chk("armed", 0, {31'h0, armed});
        acc(1'b0, PCU_ADDR_ARM, 0, 1'b0, PCU_ARM_ABORT);
        acc(1'b1, PCU_ADDR_COUNT, 32'h7, 1'b1, 0);
        acc(1'b1, PCU_ADDR_POS, 32'h7, 1'b1, 0);
        acc(1'b1, PCU_ADDR_STATUS, 32'h0, 1'b1, 0);
        acc(1'b0, PCU_ADDR_COUNT, 0, 1'b0, 1);
        a_done <= 1'b1;
        @(posedge clock);
        a_done <= 1'b0;
        acc(1'b0, PCU_ADDR_STATUS, 0, 1'b0, 3);
        a_arm <= 1'b1;
        @(posedge clock);
        a_arm <= 1'b0;
        acc(1'b0, PCU_ADDR_STATUS, 0, 1'b0, 2);
        // a second reset in mid-run must bring every word back to its reset value
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        foreach (regs[i])
            acc(1'b0, regs[i], 0, 1'b0, 0);
        chk("armed", 0, {31'h0, armed});
        close_out();
    end
endmodule // tb_top
